// ### common/tvf_pkg.sv
// constants and carrier types of the teletext line store and readout block
// assumes one clock domain and an apb master on the register side
//
// Behaviour
// - store sliced teletext lines with their error flags, both north american basic and world system formats
// - sliced lines go into an internal fifo readable by the host
// - fifo holds at most 14 basic lines or 11 world system lines
// - configurable interrupts let the host fetch a whole field at once
// - closed caption data kept in two host-readable registers, not in the fifo
// - first byte of every line is video line number bits 7 to 0
// - second byte: 00, hamming, parity, lpc errors, match 2, match 1, line bit 8
// - basic lines: three packet addresses, index, structure, blocks up to byte 35
// - world lines: magazine, row, then 32 bytes (525) or 40 bytes (625)
// - basic lines store a padding byte at 36 which the read pointer skips
// - host reads fifo bytes directly at one data location, each read the next byte
// - status bits stay set until the host writes one to them
package tvf_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FIFO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic [7:0] OFS_THRESH = 8'h14;
  localparam logic [7:0] OFS_CC1 = 8'h18;
  localparam logic [7:0] OFS_CC2 = 8'h1c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WST_BIT = 1;
  localparam int CTRL_625_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam int ST_LINE = 0;
  localparam int ST_FIELD = 1;
  localparam int ST_OVF = 2;
  localparam int ST_CC = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [3:0] THRESH_RESET = 4'h0;

  localparam logic [5:0] NABTS_LEN = 6'h24;
  localparam logic [5:0] WST525_LEN = 6'h24;
  localparam logic [5:0] WST625_LEN = 6'h2c;
  localparam logic [5:0] HDR_LEN = 6'h02;
  localparam logic [5:0] PAD_IDX = 6'h23;
  localparam logic [3:0] NABTS_LINES = 4'he;
  localparam logic [3:0] WST_LINES = 4'hb;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  typedef enum {W_IDLE, W_LN_LO, W_LN_HI, W_DATA, W_PAD} tvf_wr_e;

  typedef struct packed {
    logic [8:0] line_num;
    logic ham_err;
    logic par_err;
    logic lpc_err;
    logic match2;
    logic match1;
  } tvf_hdr_s;

  typedef struct packed {
    logic start;
    tvf_hdr_s hdr;
    logic byte_valid;
    logic [7:0] byte_data;
  } tvf_slice_s;

  typedef struct packed {
    logic valid;
    logic field;
    logic [15:0] data;
  } tvf_cc_s;
endpackage

// ### rtl/tvf_readout.sv
// teletext line store: slicer side writes lines, apb host reads bytes
// assumes slicer delivers header then payload bytes on one synchronous clock
`timescale 1ns/100ps
`default_nettype none
module tvf_readout #(
  parameter int DEPTH_W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tvf_pkg::tvf_slice_s slice_in,
  output logic slice_ready,
  input wire tvf_pkg::tvf_cc_s cc_in,
  output logic irq
);
  localparam int PW = DEPTH_W + 1;
  localparam int DEPTH = 1 << DEPTH_W;
  localparam logic [5:0] PAD_IDX_M1 = tvf_pkg::PAD_IDX - 6'h01;

  typedef struct packed {
    tvf_pkg::tvf_wr_e wst;
    tvf_pkg::tvf_hdr_s hdr;
    logic [5:0] cnt;
    logic [5:0] rd_idx;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] cmt_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] base;
    logic [3:0] lines;
    logic [2:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] thresh;
    logic [15:0] cc1;
    logic [15:0] cc2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pop_ok;
    logic slice_ready;
    logic irq;
  } tvf_state_s;

  tvf_state_s s;
  tvf_state_s n;
  logic [7:0] mem [DEPTH];
  logic wr_en;
  logic [7:0] wr_byte;
  logic commit;
  logic line_done;
  logic accept;
  logic pop;
  logic [3:0] ev;
  logic [3:0] clr;
  logic setup;
  logic acc;
  logic nabts;
  logic [5:0] len;
  logic [5:0] pay;
  logic [5:0] last_rd;
  logic [3:0] max_lines;
  logic [PW-1:0] avail;
  logic [PW-1:0] used;
  logic [7:0] head;

  assign setup = psel && !penable;
  assign acc = psel && penable && s.pready;
  assign nabts = !s.ctrl[tvf_pkg::CTRL_WST_BIT];
  // format picks line length and capacity
  assign len = nabts ? tvf_pkg::NABTS_LEN :
    (s.ctrl[tvf_pkg::CTRL_625_BIT] ? tvf_pkg::WST625_LEN : tvf_pkg::WST525_LEN);
  assign pay = len - tvf_pkg::HDR_LEN - (nabts ? 6'h01 : 6'h00);
  assign last_rd = len - (nabts ? 6'h02 : 6'h01);
  assign max_lines = nabts ? tvf_pkg::NABTS_LINES : tvf_pkg::WST_LINES;
  // only committed lines are readable, so a half-written line never leaks
  assign avail = s.cmt_ptr - s.rd_ptr;
  assign used = s.wr_ptr - s.rd_ptr;
  assign head = mem[s.rd_ptr[DEPTH_W-1:0]];
  assign accept = (s.wst == tvf_pkg::W_IDLE) && slice_in.start && s.ctrl[tvf_pkg::CTRL_EN_BIT]
    && (s.lines < max_lines)
    && ((PW+1)'(used) + (PW+1)'(len) <= (PW+1)'(DEPTH));
  // pop decided at setup: a commit before the access edge must not pop an unreturned byte
  assign pop = acc && s.pop_ok;
  assign clr = (acc && pwrite && paddr == tvf_pkg::OFS_STATUS) ? pwdata[3:0] : 4'h0;

  always_comb begin
    n = s;
    wr_en = 1'b0;
    wr_byte = 8'h00;
    commit = 1'b0;
    line_done = 1'b0;
    ev = 4'h0;
    // line writer
    unique case (s.wst)
      tvf_pkg::W_IDLE: begin
        if (accept) begin
          n.hdr = slice_in.hdr;
          n.base = s.wr_ptr;
          n.wst = tvf_pkg::W_LN_LO;
        end else if (slice_in.start && s.ctrl[tvf_pkg::CTRL_EN_BIT]) begin
          ev[tvf_pkg::ST_OVF] = 1'b1;
        end
      end
      tvf_pkg::W_LN_LO: begin
        wr_en = 1'b1;
        wr_byte = s.hdr.line_num[7:0];
        n.wst = tvf_pkg::W_LN_HI;
      end
      tvf_pkg::W_LN_HI: begin
        wr_en = 1'b1;
        wr_byte = {2'b00, s.hdr.ham_err, s.hdr.par_err, s.hdr.lpc_err,
          s.hdr.match2, s.hdr.match1, s.hdr.line_num[8]};
        n.cnt = 6'h00;
        n.slice_ready = 1'b1;
        n.wst = tvf_pkg::W_DATA;
      end
      tvf_pkg::W_DATA: begin
        if (s.slice_ready && slice_in.byte_valid) begin
          wr_en = 1'b1;
          wr_byte = slice_in.byte_data;
          n.cnt = s.cnt + 6'h01;
          if (s.cnt == pay - 6'h01) begin
            n.slice_ready = 1'b0;
            if (nabts) begin
              n.wst = tvf_pkg::W_PAD;
            end else begin
              commit = 1'b1;
              n.wst = tvf_pkg::W_IDLE;
            end
          end
        end
      end
      tvf_pkg::W_PAD: begin
        wr_en = 1'b1;
        wr_byte = tvf_pkg::PAD_BYTE;
        commit = 1'b1;
        n.wst = tvf_pkg::W_IDLE;
      end
    endcase
    if (wr_en) begin
      n.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (commit) begin
      n.cmt_ptr = n.wr_ptr;
      ev[tvf_pkg::ST_LINE] = 1'b1;
      // field event once the stored line count reaches the programmed level
      if (s.thresh != 4'h0 && s.lines + 4'h1 >= s.thresh) begin
        ev[tvf_pkg::ST_FIELD] = 1'b1;
      end
    end
    // reader: the pad byte is jumped over together with the last payload byte
    if (pop) begin
      if (nabts && s.rd_idx == PAD_IDX_M1) begin
        n.rd_ptr = s.rd_ptr + PW'(2);
      end else begin
        n.rd_ptr = s.rd_ptr + PW'(1);
      end
      if (s.rd_idx == last_rd) begin
        n.rd_idx = 6'h00;
        line_done = 1'b1;
      end else begin
        n.rd_idx = s.rd_idx + 6'h01;
      end
    end
    n.lines = s.lines + 4'(commit) - 4'(line_done);
    // closed caption goes to registers, never into the fifo
    if (cc_in.valid) begin
      if (cc_in.field) begin
        n.cc2 = cc_in.data;
      end else begin
        n.cc1 = cc_in.data;
      end
      ev[tvf_pkg::ST_CC] = 1'b1;
    end
    // set beats clear in the same cycle
    n.status = (s.status & ~clr) | ev;
    // apb writes land at the access edge
    if (acc && pwrite) begin
      unique case (paddr)
        tvf_pkg::OFS_CTRL: n.ctrl = pwdata[2:0];
        tvf_pkg::OFS_MASK: n.mask = pwdata[3:0];
        tvf_pkg::OFS_THRESH: n.thresh = pwdata[3:0];
        default: begin
        end
      endcase
    end
    n.irq = |(n.status & n.mask);
    // read data and ready are prepared in the setup cycle: no wait states
    n.pready = setup;
    n.pop_ok = setup && !pwrite && (paddr == tvf_pkg::OFS_FIFO) && (avail != '0);
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (setup) begin
      unique case (paddr)
        tvf_pkg::OFS_CTRL: n.prdata = {29'h0, s.ctrl};
        // empty read returns zero here, which the host must treat as undefined
        tvf_pkg::OFS_FIFO: n.prdata = {24'h0, (avail != '0) ? head : 8'h00};
        tvf_pkg::OFS_STATUS: n.prdata = {28'h0, s.status};
        tvf_pkg::OFS_MASK: n.prdata = {28'h0, s.mask};
        tvf_pkg::OFS_LEVEL: n.prdata = {12'h0, s.lines, 16'(avail)};
        tvf_pkg::OFS_THRESH: n.prdata = {28'h0, s.thresh};
        tvf_pkg::OFS_CC1: n.prdata = {16'h0, s.cc1};
        tvf_pkg::OFS_CC2: n.prdata = {16'h0, s.cc2};
        default: n.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{wst: tvf_pkg::W_IDLE, ctrl: tvf_pkg::CTRL_RESET, status: tvf_pkg::STATUS_RESET,
        mask: tvf_pkg::MASK_RESET, thresh: tvf_pkg::THRESH_RESET, default: '0};
    end else begin
      s <= n;
    end
  end

  // storage has no reset: only committed bytes are ever read back
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[s.wr_ptr[DEPTH_W-1:0]] <= wr_byte;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign slice_ready = s.slice_ready;
  assign irq = s.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_accept;
    accept;
  endsequence
  sequence seq_hdr_lo;
    wr_en && wr_byte == s.hdr.line_num[7:0];
  endsequence
  sequence seq_hdr_hi;
    wr_en && wr_byte[7:6] == 2'b00 && wr_byte[0] == s.hdr.line_num[8]
      && wr_byte[5] == s.hdr.ham_err && wr_byte[1] == s.hdr.match1;
  endsequence

  AST_HDR_ORDER:
    assert property (seq_accept |=> seq_hdr_lo ##1 seq_hdr_hi)
    else $error("line header bytes not written in order");
  AST_LINE_LEN:
    assert property (commit |-> PW'(n.cmt_ptr - s.base) == PW'(len))
    else $error("committed line length wrong for format");
  AST_PAD_SKIP:
    assert property (pop && nabts && s.rd_idx == PAD_IDX_M1 |=> s.rd_ptr == $past(s.rd_ptr) + PW'(2))
    else $error("padding byte not skipped");
  AST_EMPTY_READ:
    assert property (acc && !pwrite && paddr == tvf_pkg::OFS_FIFO && avail == '0 |=> $stable(s.rd_ptr))
    else $error("read of empty fifo moved the pointer");
  AST_CAPACITY:
    assert property (s.lines <= (nabts ? tvf_pkg::NABTS_LINES : tvf_pkg::WST_LINES))
    else $error("more lines stored than the format allows");
  AST_STICKY:
    assert property (s.status[tvf_pkg::ST_LINE] && !clr[tvf_pkg::ST_LINE] |=> s.status[tvf_pkg::ST_LINE])
    else $error("status bit dropped without a clear");
  AST_IRQ_LEVEL:
    assert property (##1 irq == |(s.status & s.mask))
    else $error("interrupt out of step with masked status");
  AST_ZERO_WAIT:
    assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  AST_CC_REG:
    assert property (cc_in.valid && !cc_in.field |=> s.cc1 == $past(cc_in.data) && $stable(s.wr_ptr) [*1])
    else $error("caption data not held in its register");
endmodule
`default_nettype wire

// ### verif/tvf_host_model.sv
// host model: apb master issuing single reads and writes
// assumes the caller runs from one process, right after a rising edge
`timescale 1ns/100ps
`default_nettype none
module tvf_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // idle edge before setup so no strobe is assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data bus shows the inverse, never the stale word
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_teletext_vbi_fifo_readout.sv
// bench: slicer driven here, host model on apb, queue model of the fifo
// assumes the design answers each apb access and signals line commit by irq
`timescale 1ns/100ps
`default_nettype none
module tb_teletext_vbi_fifo_readout;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, slice_ready, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'hb825;
  tvf_pkg::tvf_slice_s slice_in = '0;
  tvf_pkg::tvf_cc_s cc_in = '0;
  logic [7:0] expq[$];
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  tvf_readout dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slice_in(slice_in), .slice_ready(slice_ready), .cc_in(cc_in), .irq(irq));
  tvf_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk_bit(e, xe);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
    chk_bit(e, 1'b0);
  endtask
  // a dropped line gets no payload: its bytes would never be taken
  task automatic send(input int nb, input bit keep);
    tvf_pkg::tvf_hdr_s h;
    logic [7:0] b;
    seed = lfsr(seed);
    h = seed[13:0];
    b = seed[23:16];
    @(posedge pclk);
    slice_in.start <= 1'b1;
    slice_in.hdr <= h;
    if (keep) expq.push_back(h.line_num[7:0]);
    if (keep) expq.push_back({2'b00, h.ham_err, h.par_err, h.lpc_err, h.match2, h.match1, h.line_num[8]});
    @(posedge pclk);
    slice_in.start <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      slice_in.byte_valid <= 1'b1;
      slice_in.byte_data <= b;
      do @(posedge pclk); while (slice_ready !== 1'b1);
      expq.push_back(b);
      b = b + 8'h0d;
    end
    slice_in.byte_valid <= 1'b0;
    slice_in.byte_data <= ~b;
    repeat (2) @(posedge pclk);
  endtask
  task automatic drain(input int nb);
    for (int i = 0; i < nb; i++) rd(tvf_pkg::OFS_FIFO, 32'hffffffff, {24'h0, expq.pop_front()}, 1'b0);
  endtask
  task automatic complete_run;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // disabled block must neither store nor flag a line
    send(0, 1'b0);
    rd(tvf_pkg::OFS_CTRL, 32'hffffffff, 32'h0, 1'b0);
    rd(tvf_pkg::OFS_STATUS, 32'hffffffff, 32'h0, 1'b0);
    rd(tvf_pkg::OFS_FIFO, 32'hffffffff, 32'h0, 1'b0);
    rd(tvf_pkg::OFS_LEVEL, 32'hffffffff, 32'h0, 1'b0);
    rd(8'h20, 32'hffffffff, 32'h0, 1'b1);
    wr(tvf_pkg::OFS_MASK, 32'h1);
    wr(tvf_pkg::OFS_CTRL, 32'h1);
    send(33, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk_bit(irq, 1'b1);
    rd(tvf_pkg::OFS_STATUS, 32'hf, 32'h1, 1'b0);
    rd(tvf_pkg::OFS_STATUS, 32'hf, 32'h1, 1'b0);
    wr(tvf_pkg::OFS_STATUS, 32'h1);
    rd(tvf_pkg::OFS_STATUS, 32'hf, 32'h0, 1'b0);
    chk_bit(irq, 1'b0);
    drain(35);
    wr(tvf_pkg::OFS_CTRL, 32'h3);
    send(34, 1'b1);
    drain(36);
    wr(tvf_pkg::OFS_CTRL, 32'h7);
    send(42, 1'b1);
    drain(44);
    wr(tvf_pkg::OFS_CTRL, 32'h1);
    wr(tvf_pkg::OFS_THRESH, 32'he);
    wr(tvf_pkg::OFS_MASK, 32'hf);
    // fifteenth line must be refused and flagged as dropped
    for (int i = 0; i < 14; i++) send(33, 1'b1);
    send(0, 1'b0);
    rd(tvf_pkg::OFS_LEVEL, 32'h000f0000, 32'h000e0000, 1'b0);
    rd(tvf_pkg::OFS_STATUS, 32'hf, 32'h7, 1'b0);
    chk_bit(irq, 1'b1);
    for (int i = 0; i < 14; i++) drain(35);
    rd(tvf_pkg::OFS_FIFO, 32'hffffffff, 32'h0, 1'b0);
    seed = lfsr(seed);
    @(posedge pclk);
    cc_in <= '{valid: 1'b1, field: 1'b1, data: seed[15:0]};
    @(posedge pclk);
    cc_in.valid <= 1'b0;
    rd(tvf_pkg::OFS_CC2, 32'hffff, {16'h0, seed[15:0]}, 1'b0);
    rd(tvf_pkg::OFS_STATUS, 32'h8, 32'h8, 1'b0);
    @(posedge pclk);
    cc_in <= '{valid: 1'b1, field: 1'b0, data: ~seed[15:0]};
    @(posedge pclk);
    cc_in.valid <= 1'b0;
    rd(tvf_pkg::OFS_CC1, 32'hffff, {16'h0, ~seed[15:0]}, 1'b0);
    rd(tvf_pkg::OFS_CC2, 32'hffff, {16'h0, seed[15:0]}, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
